// ---- rtl/jlop_frame_build.sv ----
// Combinational frame builder: pads and packs one lane's samples MSB first
module jlop_frame_build #(
	parameter int NCONV = 8,
	parameter int SW = 16,
	parameter int FW = NCONV * SW
) (
	// Samples, right justified in SW bits, converter 1 first
	input wire logic [SW-1:0] sample [NCONV],
	// Effective configuration
	input wire logic [4:0] res,
	input wire logic [4:0] ser,
	input wire logic [3:0] nconv,
	// Packed frame, first octet in the top bits
	output logic [FW-1:0] frame
);

	// Left justify each sample so the pad zeros land at its low end
	always_comb begin
		int pos;
		logic [SW-1:0] word;
		frame = '0;
		pos = 0;
		word = '0;
		for (int i = 0; i < NCONV; i++) begin
			// Same arrangement whatever converters feed the lane
			if (i < int'(nconv)) begin
				word = sample[i] << (SW - int'(res)); // Zero tail
				// Next word fills any partial nibble
				frame = frame | (FW'(word) << (FW - SW - pos));
				pos = pos + int'(ser); // Ascending converter order
			end
		end
	end

endmodule

// ---- rtl/jlop_lane_packer.sv ----
// Package of packer constants and the lane octet packer top
// How it works
// - Eight converters, pad low zeros, 12-16 octets
// - Four converters, unpadded, 5-8 octets
// - Four converters, padded words packed, 6-8 octets
// - First converter MSBs open first octet
// - Ten-bit in twelve: three nibbles, zero tail
// - Every lane packs the same way
// - Partial nibbles filled by following word
package jlop_pkg;
	localparam int OCTET_W = 8;
	localparam int NIBBLE_W = 4;
	localparam logic [3:0] NAL_EIGHT = 4'h8;
	localparam logic [3:0] NAL_FOUR = 4'h4;
	localparam logic [4:0] RES_TEN = 5'h0a;
	localparam logic [4:0] SER_TWELVE = 5'h0c;
	localparam logic [4:0] RES_TWELVE = 5'h0c;
	localparam logic [4:0] SER_FOURTEEN = 5'h0e;
	localparam logic [4:0] WIDTH_MIN = 5'h0a;
	localparam logic [4:0] WIDTH_MAX = 5'h10;
	typedef enum logic [1:0] {
		JLOP_IDLE = 2'b01,
		JLOP_SEND = 2'b10
	} jlop_state_e;
endpackage

module jlop_lane_packer import jlop_pkg::*; #(
	parameter int NCONV = 8,
	parameter int SW = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Configuration
	input wire logic [3:0] converters_per_lane,
	input wire logic [4:0] resolution_setting,
	input wire logic [4:0] serial_width_setting,
	output logic config_error,
	// Sample side
	input wire logic [SW-1:0] sample [NCONV],
	input wire logic sample_valid,
	output logic sample_ready,
	// Octet side towards the link layer
	output logic [7:0] octet_data,
	output logic octet_valid,
	output logic octet_first,
	output logic octet_last,
	input wire logic octet_ready
);

	localparam int FW = NCONV * SW;

	// Octets in a frame: converters times width over eight
	function automatic logic [4:0] frame_octets(input logic [3:0] n,
		input logic [4:0] w);
		logic [8:0] bits;
		bits = 9'(n) * 9'(w);
		return 5'(bits / 9'(OCTET_W));
	endfunction

	jlop_state_e state;
	logic [FW-1:0] frame_comb;
	logic [FW-1:0] frame_reg;
	logic [4:0] ser_eff;
	logic [4:0] octet_total;
	logic [4:0] octet_idx;
	logic take;
	logic give;

	// Width below resolution is refused; packer falls back to resolution
	assign config_error = (serial_width_setting < resolution_setting) ||
		(resolution_setting < WIDTH_MIN) || (serial_width_setting > WIDTH_MAX);
	assign ser_eff = (serial_width_setting < resolution_setting) ?
		resolution_setting : serial_width_setting;

	jlop_frame_build #(
		.NCONV(NCONV),
		.SW(SW),
		.FW(FW)
	) u_build (
		.sample(sample),
		.res(resolution_setting),
		.ser(ser_eff),
		.nconv(converters_per_lane),
		.frame(frame_comb)
	);

	// Handshakes
	assign sample_ready = (state == JLOP_IDLE);
	assign take = sample_valid && sample_ready;
	assign give = octet_valid && octet_ready;
	assign octet_valid = (state == JLOP_SEND);
	assign octet_data = frame_reg[FW-1 -: OCTET_W];
	assign octet_first = octet_valid && (octet_idx == 5'h00);
	assign octet_last = octet_valid && (octet_idx == octet_total - 5'h01);

	// Frame state: whole frame sent before the next sample is taken
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= JLOP_IDLE;
		end else begin
			case (state)
				JLOP_IDLE: begin
					if (take) begin
						state <= JLOP_SEND;
					end
				end
				JLOP_SEND: begin
					if (give && octet_last) begin
						state <= JLOP_IDLE;
					end
				end
				default: begin
					state <= JLOP_IDLE;
				end
			endcase
		end
	end

	// Frame shift register, octets leave in ascending order
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			frame_reg <= '0;
		end else if (take) begin
			frame_reg <= frame_comb;
		end else if (give) begin
			frame_reg <= frame_reg << OCTET_W;
		end
	end

	// Octet position and frame length
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			octet_idx <= '0;
			octet_total <= '0;
		end else if (take) begin
			octet_idx <= '0;
			octet_total <= frame_octets(converters_per_lane, ser_eff);
		end else if (give) begin
			octet_idx <= octet_idx + 5'h01;
		end
	end

	// Eight converters padded: frame of ser octets
	property p_len_eight_pad;
		@(posedge clock) disable iff (!nrst)
		take && converters_per_lane == NAL_EIGHT &&
		serial_width_setting > resolution_setting |=>
		octet_total == $past(serial_width_setting);
	endproperty
	a_len_eight_pad: assert property (p_len_eight_pad)
		else $error("eight converter padded frame length wrong");

	// Four converters unpadded: half ser octets
	property p_len_four_exact;
		@(posedge clock) disable iff (!nrst)
		take && converters_per_lane == NAL_FOUR &&
		serial_width_setting == resolution_setting |=>
		octet_total == ($past(serial_width_setting) >> 1);
	endproperty
	a_len_four_exact: assert property (p_len_four_exact)
		else $error("four converter frame length wrong");

	// Four converters padded: half ser octets
	property p_len_four_pad;
		@(posedge clock) disable iff (!nrst)
		take && converters_per_lane == NAL_FOUR &&
		serial_width_setting > resolution_setting |=>
		octet_total == ($past(serial_width_setting) >> 1);
	endproperty
	a_len_four_pad: assert property (p_len_four_pad)
		else $error("four converter padded frame length wrong");

	// First nibble is converter one's top bits
	property p_first_nibble;
		@(posedge clock) disable iff (!nrst)
		take && !config_error |=> octet_first &&
		octet_data[OCTET_W-1 -: NIBBLE_W] ==
		4'($past(sample[0]) >> ($past(resolution_setting) - 5'h04));
	endproperty
	a_first_nibble: assert property (p_first_nibble)
		else $error("first nibble not converter one msbs");

	// Ten in twelve: third nibble ends in two zeros
	property p_ten_tail;
		@(posedge clock) disable iff (!nrst)
		take && resolution_setting == RES_TEN &&
		serial_width_setting == SER_TWELVE |=>
		frame_reg[FW-11 -: 2] == 2'h0 &&
		frame_reg[FW-9 -: 2] == $past(sample[0][1:0]);
	endproperty
	a_ten_tail: assert property (p_ten_tail)
		else $error("ten bit tail nibble wrong");

	// Twelve in fourteen: zeros then next sample's top bits
	property p_nibble_fill;
		@(posedge clock) disable iff (!nrst)
		take && resolution_setting == RES_TWELVE &&
		serial_width_setting == SER_FOURTEEN |=>
		frame_reg[FW-13 -: 2] == 2'h0 &&
		frame_reg[FW-15 -: 2] == $past(sample[1][11:10]);
	endproperty
	a_nibble_fill: assert property (p_nibble_fill)
		else $error("partial nibble not filled by next word");

	// Refused width flagged and clamped
	property p_width_clamp;
		@(posedge clock) disable iff (!nrst)
		serial_width_setting < resolution_setting |->
		config_error && ser_eff == resolution_setting;
	endproperty
	a_width_clamp: assert property (p_width_clamp)
		else $error("narrow serial width not refused");

	// Octets follow each other until the last, then the packer frees
	property p_frame_flow;
		@(posedge clock) disable iff (!nrst)
		give |=> (octet_valid && octet_idx == $past(octet_idx) + 5'h01 &&
		octet_data == $past(frame_reg[FW-OCTET_W-1 -: OCTET_W])) ||
		($past(octet_last) && sample_ready);
	endproperty
	a_frame_flow: assert property (p_frame_flow)
		else $error("octet order broken");

	// No overlap while octets are valid: sample ready only between frames
	property p_no_overlap;
		@(posedge clock) disable iff (!nrst)
		octet_valid |-> !sample_ready;
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("sample taken mid frame");

endmodule

// ---- sim/jlop_link_sink.sv ----
// Link layer model: accepts octets, optionally stalling
module jlop_link_sink (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Octet side
	input wire logic [7:0] octet_data,
	input wire logic octet_valid,
	output logic octet_ready,
	// Stall every other cycle
	input wire logic slow
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got [$];
	// Ready pattern, changed off the sampling edge
	always @(negedge clock or negedge nrst) begin
		if (!nrst)
			octet_ready <= 1'b0;
		else
			octet_ready <= slow ? ~octet_ready : 1'b1;
	end
	// Octets kept in arrival order
	always @(posedge clock) begin
		if (octet_valid && octet_ready)
			got.push_back(octet_data);
	end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the lane octet packer
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, nrst = 0, sv = 0, slow = 0, rdy, cfg_err, srdy;
	logic [3:0] cpl = 4'h8;
	logic [4:0] rs = 5'h10, sw = 5'h10;
	logic [15:0] smp [8] = '{default: 16'h0};
	logic [7:0] od;
	logic ov;
	logic ofirst, olast;
	logic [1:0] marks [$];
	int n_mismatch = 0, comparisons = 0;
	// Clock at 20 MHz
	always #25 clock = ~clock;
	jlop_lane_packer dut (.clock(clock), .nrst(nrst),
		.converters_per_lane(cpl), .resolution_setting(rs),
		.serial_width_setting(sw), .config_error(cfg_err),
		.sample(smp), .sample_valid(sv), .sample_ready(srdy),
		.octet_data(od), .octet_valid(ov), .octet_first(ofirst),
		.octet_last(olast), .octet_ready(rdy));
	jlop_link_sink link (.clock(clock), .nrst(nrst), .octet_data(od),
		.octet_valid(ov), .octet_ready(rdy), .slow(slow));
	// Frame markers of every accepted octet
	always @(posedge clock)
		if (ov && rdy)
			marks.push_back({ofirst, olast});
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One frame: offer samples, expect padded words packed MSB first
	task automatic send(input int nal, input int res, input int ser);
		logic [127:0] f;
		int n, pos, t, e;
		f = '0;
		pos = 128;
		t = 0;
		// A narrow width is refused and packed at the resolution
		e = (ser < res) ? res : ser;
		link.got.delete();
		marks.delete();
		@(negedge clock);
		cpl = 4'(nal);
		rs = 5'(res);
		sw = 5'(ser);
		for (int i = 0; i < 8; i++)
			smp[i] = 16'(16'h9c5a + i * 16'h3171) & 16'((1 << res) - 1);
		for (int i = 0; i < nal; i++) begin
			for (int b = e - 1; b >= 0; b--) begin
				pos--;
				f[pos] = (b >= e - res) ? smp[i][b - (e - res)] : 1'b0;
			end
		end
		n = nal * e / 8;
		sv = 1'b1;
		while (srdy !== 1'b1 && t < 50) begin
			@(negedge clock);
			t++;
		end
		@(negedge clock);
		sv = 1'b0;
		check({6'h0, srdy, ov}, 8'h01);
		while (link.got.size() < n && t < 200) begin
			@(negedge clock);
			t++;
		end
		if (t >= 200) n_mismatch++;
		check({6'h0, srdy, ov}, 8'h02);
		check(8'(link.got.size()), 8'(n));
		for (int k = 0; k < n; k++) begin
			check(link.got[k], f[127 - 8 * k -: 8]);
			check({6'h0, marks[k]}, {6'h0, k == 0, k == n - 1});
		end
	endtask
	task automatic s_eight_padded;
		send(8, 10, 12);
		send(8, 12, 14);
		send(8, 14, 16);
	endtask
	task automatic s_four_equal;
		for (int r = 10; r <= 16; r += 2)
			send(4, r, r);
	endtask
	task automatic s_four_padded;
		send(4, 10, 12);
		send(4, 12, 14);
		send(4, 14, 16);
	endtask
	task automatic s_stall;
		slow = 1'b1;
		send(8, 16, 16);
		send(8, 10, 10);
		slow = 1'b0;
	endtask
	task automatic s_bad_config;
		@(negedge clock);
		rs = 5'h0e;
		sw = 5'h0c;
		#1 check({7'h0, cfg_err}, 8'h01);
		@(negedge clock);
		sw = 5'h0e;
		#1 check({7'h0, cfg_err}, 8'h00);
		sw = 5'h11;
		#1 check({7'h0, cfg_err}, 8'h01);
		send(4, 14, 12);
	endtask
	// Reset in mid-frame clears the frame, then a new frame runs
	task automatic s_reset;
		@(negedge clock);
		cpl = 4'h8;
		rs = 5'h10;
		sw = 5'h10;
		sv = 1'b1;
		@(negedge clock);
		sv = 1'b0;
		@(negedge clock);
		nrst = 1'b0;
		#1 check({6'h0, srdy, ov}, 8'h02);
		check(od, 8'h00);
		@(negedge clock);
		nrst = 1'b1;
		send(4, 12, 12);
	endtask
	task automatic print_verdict;
		$display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(negedge clock);
		nrst = 1'b1;
		s_eight_padded();
		s_four_equal();
		s_four_padded();
		s_stall();
		s_reset();
		s_bad_config();
		print_verdict();
	end
	// Watchdog
	initial begin
		#200us;
		n_mismatch++;
		print_verdict();
	end
endmodule
